//--- common/emsb_pkg.sv
`default_nettype none
package emsb_pkg;
    localparam int ADDR_W_LARGE = 16;
    localparam int ADDR_W_SMALL = 11;
    localparam logic [15:0] VEC_LO_ADDR = 16'h0000;
    localparam logic [15:0] VEC_HI_ADDR = 16'h0001;
    localparam logic [7:0] LANE_IDLE = 8'h00;
    localparam logic [7:0] UPPER_IDLE = 8'h00;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_LATCH = 6'h04,
        ST_DATA = 6'h08,
        ST_DEND = 6'h10,
        ST_DONE = 6'h20
    } emsb_state_t;

    typedef enum logic [2:0] {
        BOOT_LO = 3'h1,
        BOOT_HI = 3'h2,
        BOOT_RUN = 3'h4
    } emsb_boot_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic write;
        logic internal;
    } emsb_req_t;

    typedef struct packed {
        logic addr_strobe_n;
        logic data_strobe_n;
        logic rw;
        logic [7:0] upper_addr_lines;
        logic [7:0] lane_out;
        logic lane_oe;
    } emsb_pins_t;
endpackage
`default_nettype wire

//--- rtl/emsb_boot.sv
`default_nettype none
// fetches the start vector through the strobe bus after reset
module emsb_boot
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic cyc_done,
    input wire logic [7:0] cyc_rdata,
    output logic boot_req,
    output logic [15:0] boot_addr,
    output logic boot_busy,
    output logic [15:0] start_vec
);
    emsb_pkg::emsb_boot_t state;
    emsb_pkg::emsb_boot_t next_state;
    logic [15:0] next_vec;

    assign boot_busy = (state != emsb_pkg::BOOT_RUN);
    assign boot_req = boot_busy;
    assign boot_addr = (state == emsb_pkg::BOOT_LO) ? emsb_pkg::VEC_LO_ADDR
                                                    : emsb_pkg::VEC_HI_ADDR;

    always_comb
    begin
        next_state = state;
        next_vec = start_vec;
        case (state)
            emsb_pkg::BOOT_LO:
            begin
                if (cyc_done)
                begin
                    // high byte of vector at 00h
                    next_vec = {cyc_rdata, start_vec[7:0]};
                    next_state = emsb_pkg::BOOT_HI;
                end
            end
            emsb_pkg::BOOT_HI:
            begin
                if (cyc_done)
                begin
                    next_vec = {start_vec[15:8], cyc_rdata};
                    next_state = emsb_pkg::BOOT_RUN;
                end
            end
            emsb_pkg::BOOT_RUN:
            begin
                next_state = emsb_pkg::BOOT_RUN;
            end
            default:
            begin
                next_state = emsb_pkg::BOOT_LO;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= emsb_pkg::BOOT_LO;
            start_vec <= 16'h0000;
        end
        else
        begin
            state <= next_state;
            start_vec <= next_vec;
        end
    end
endmodule
`default_nettype wire

//--- rtl/emsb_top.sv
`default_nettype none
// Function
// - The address strobe goes low for exactly one pulse at the start of every memory cycle.
// - Address and direction lines are valid by the address strobe rising edge; write data goes on the lane one cycle after it.
// - In a write the output data is on the lane by the data strobe falling edge.
// - A cycle to on-chip memory keeps the data strobe high throughout.
// - The read/write line is low only for external writes, high otherwise.
// - After reset release the start vector is fetched from 00h and 01h and execution starts there.
// - The external address width is a constant, 16 bits large package or 11 bits small.
// - Data moves over the eight shared lane lines timed by the data strobe, which also carry low address.
module emsb_top
#(
    parameter int ADDR_W = emsb_pkg::ADDR_W_LARGE
)
(
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic REQ_VALID,
    input wire logic [15:0] REQ_ADDR,
    input wire logic [7:0] REQ_WDATA,
    input wire logic REQ_WRITE,
    input wire logic REQ_INTERNAL,
    output logic REQ_READY,
    output logic DONE,
    output logic [7:0] RDATA,
    output logic BOOTED,
    output logic [15:0] START_VEC,
    output logic ADDR_STROBE_N,
    output logic DATA_STROBE_N,
    output logic RW,
    output logic [7:0] UPPER_ADDR_LINES,
    output logic [7:0] MUX_ADDR_DATA_LANE_OUT,
    output logic MUX_ADDR_DATA_LANE_OE,
    input wire logic [7:0] MUX_ADDR_DATA_LANE_IN
);
    emsb_pkg::emsb_state_t state;
    emsb_pkg::emsb_state_t next_state;
    emsb_pkg::emsb_req_t cur;
    emsb_pkg::emsb_req_t sel_req;
    emsb_pkg::emsb_pins_t pins;
    emsb_pkg::emsb_pins_t next_pins;
    logic boot_req;
    logic boot_busy;
    logic [15:0] boot_addr;
    logic [15:0] boot_vec;
    logic cyc_done;
    logic [7:0] rdata;
    logic start;
    logic [15:0] addr_mask;
    logic [7:0] upper_mask;

    // unused upper lines stay low on the small package
    assign addr_mask = 16'hFFFF >> (16 - ADDR_W);
    assign upper_mask = addr_mask[15:8];

    assign sel_req.addr = boot_busy ? boot_addr : REQ_ADDR;
    assign sel_req.wdata = boot_busy ? 8'h00 : REQ_WDATA;
    assign sel_req.write = boot_busy ? 1'b0 : REQ_WRITE;
    assign sel_req.internal = boot_busy ? 1'b0 : REQ_INTERNAL;
    assign start = (state == emsb_pkg::ST_IDLE) && (boot_busy ? boot_req : REQ_VALID);

    emsb_boot u_boot
    (
        .clk(REF_CLK),
        .rstn(RSTN),
        .cyc_done(cyc_done && boot_busy),
        .cyc_rdata(rdata),
        .boot_req(boot_req),
        .boot_addr(boot_addr),
        .boot_busy(boot_busy),
        .start_vec(boot_vec)
    );

    always_comb
    begin
        next_state = state;
        next_pins = pins;
        case (state)
            emsb_pkg::ST_IDLE:
            begin
                if (start)
                begin
                    // address phase: strobe low, address on the lane
                    next_pins.addr_strobe_n = 1'b0;
                    next_pins.upper_addr_lines = sel_req.addr[15:8] & upper_mask;
                    next_pins.lane_out = sel_req.addr[7:0];
                    next_pins.lane_oe = 1'b1;
                    next_pins.rw = !(sel_req.write && !sel_req.internal);
                    next_state = emsb_pkg::ST_ADDR;
                end
            end
            emsb_pkg::ST_ADDR:
            begin
                next_pins.addr_strobe_n = 1'b1;
                next_state = emsb_pkg::ST_LATCH;
            end
            emsb_pkg::ST_LATCH:
            begin
                // data phase: write data out or lane released
                next_pins.lane_out = cur.write ? cur.wdata : emsb_pkg::LANE_IDLE;
                next_pins.lane_oe = cur.write && !cur.internal;
                next_state = emsb_pkg::ST_DATA;
            end
            emsb_pkg::ST_DATA:
            begin
                next_pins.data_strobe_n = cur.internal;
                next_state = emsb_pkg::ST_DEND;
            end
            emsb_pkg::ST_DEND:
            begin
                next_pins.data_strobe_n = 1'b1;
                next_state = emsb_pkg::ST_DONE;
            end
            emsb_pkg::ST_DONE:
            begin
                next_pins.lane_oe = 1'b0;
                next_pins.lane_out = emsb_pkg::LANE_IDLE;
                next_pins.rw = 1'b1;
                next_state = emsb_pkg::ST_IDLE;
            end
            default:
            begin
                next_state = emsb_pkg::ST_IDLE;
            end
        endcase
    end

    assign cyc_done = (state == emsb_pkg::ST_DEND);

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            state <= emsb_pkg::ST_IDLE;
            cur <= '0;
            pins <= '{addr_strobe_n: 1'b1, data_strobe_n: 1'b1, rw: 1'b1,
                      upper_addr_lines: emsb_pkg::UPPER_IDLE,
                      lane_out: emsb_pkg::LANE_IDLE, lane_oe: 1'b0};
        end
        else
        begin
            state <= next_state;
            pins <= next_pins;
            if (start)
            begin
                cur <= sel_req;
            end
        end
    end

    // lane sampled as the data strobe rises
    assign rdata = cur.internal ? 8'h00 : MUX_ADDR_DATA_LANE_IN;

    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            RDATA <= 8'h00;
            DONE <= 1'b0;
            REQ_READY <= 1'b0;
            BOOTED <= 1'b0;
            START_VEC <= 16'h0000;
        end
        else
        begin
            DONE <= cyc_done && !boot_busy;
            if (cyc_done && !cur.write)
            begin
                RDATA <= rdata;
            end
            REQ_READY <= !boot_busy && (next_state == emsb_pkg::ST_IDLE);
            BOOTED <= !boot_busy;
            START_VEC <= boot_vec;
        end
    end

    assign ADDR_STROBE_N = pins.addr_strobe_n;
    assign DATA_STROBE_N = pins.data_strobe_n;
    assign RW = pins.rw;
    assign UPPER_ADDR_LINES = pins.upper_addr_lines;
    assign MUX_ADDR_DATA_LANE_OUT = pins.lane_out;
    assign MUX_ADDR_DATA_LANE_OE = pins.lane_oe;
endmodule
`default_nettype wire

//--- tb/emsb_checker.sv
`default_nettype none
module emsb_checker
#(
    parameter int ADDR_W = 16
)
(
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic REQ_INTERNAL,
    input wire logic REQ_READY,
    input wire logic DONE,
    input wire logic ADDR_STROBE_N,
    input wire logic DATA_STROBE_N,
    input wire logic RW,
    input wire logic [7:0] UPPER_ADDR_LINES,
    input wire logic [7:0] MUX_ADDR_DATA_LANE_OUT,
    input wire logic MUX_ADDR_DATA_LANE_OE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge REF_CLK);
    endclocking
    default disable iff (!RSTN);
    wire logic take = REQ_READY && REQ_VALID;
    wire logic ext_wr_take = take && REQ_WRITE && !REQ_INTERNAL;
    AST_AS_ONE: assert property ($fell(ADDR_STROBE_N) |=> $rose(ADDR_STROBE_N))
        else $error("address strobe width");
    AST_TAKE_AS: assert property (take |=> $fell(ADDR_STROBE_N))
        else $error("no address strobe");
    AST_ADDR_PHASE: assert property (!ADDR_STROBE_N |-> MUX_ADDR_DATA_LANE_OE)
        else $error("lane not driven in address phase");
    AST_AS_RISE: assert property ($rose(ADDR_STROBE_N) |->
        $stable(MUX_ADDR_DATA_LANE_OUT) && $stable(RW) && $stable(UPPER_ADDR_LINES))
        else $error("address moved at strobe rise");
    AST_WR_DATA: assert property ($fell(DATA_STROBE_N) && !RW |->
        MUX_ADDR_DATA_LANE_OE && $stable(MUX_ADDR_DATA_LANE_OUT))
        else $error("write data late");
    AST_RD_FREE: assert property (!DATA_STROBE_N && RW |-> !MUX_ADDR_DATA_LANE_OE)
        else $error("lane driven in read");
    AST_DS_ORDER: assert property ($fell(DATA_STROBE_N) |->
        $past(ADDR_STROBE_N, 3) == 1'b0 ##1 DATA_STROBE_N)
        else $error("data strobe placement");
    AST_INT_NO_DS: assert property (take && REQ_INTERNAL |=> DATA_STROBE_N [*6])
        else $error("data strobe on internal cycle");
    AST_RW_WRITE: assert property ($fell(RW) |-> $past(ext_wr_take))
        else $error("write line low without write");
    AST_DONE_RW: assert property (take |-> ##5 DONE ##1 RW)
        else $error("cycle end");
    AST_UPPER: assert property (!ADDR_STROBE_N |->
        (UPPER_ADDR_LINES >> (ADDR_W - 8)) == 8'h00)
        else $error("upper lines beyond width");
endmodule
`default_nettype wire

//--- tb/emsb_mem_model.sv
`default_nettype none
module emsb_mem_model
(
    input wire logic clk,
    input wire logic as_n,
    input wire logic ds_n,
    input wire logic rw,
    input wire logic [7:0] upper,
    input wire logic [7:0] dut_out,
    input wire logic dut_oe,
    output logic [7:0] lane
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    logic [15:0] addr;
    logic [7:0] last = 8'h00;
    wire logic mem_oe = !ds_n && rw;
    initial
    begin
        mem[0] = 8'h12;
        mem[1] = 8'h34;
    end
    always @(posedge as_n) addr = {upper, lane};
    always @(posedge ds_n) if (!rw) mem[addr] = lane;
    always @(posedge clk) last <= lane;
    // released lane shows a moving pattern
    assign lane = mem_oe ? mem[addr] : dut_oe ? dut_out : ~last;
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic valid = 1'b0;
    emsb_pkg::emsb_req_t req = '0;
    logic ready, done, booted, as_n, ds_n, rw, oe;
    logic [7:0] rdata, upper, lane_out, lane;
    logic [15:0] start_vec;
    int failures = 0;
    int checks = 0;
    int rw_lows = 0;
    always #2.5 clk = ~clk;
    always @(negedge clk) if (rw === 1'b0) rw_lows++;
    emsb_top #(.ADDR_W(emsb_pkg::ADDR_W_SMALL)) dut (.REF_CLK(clk), .RSTN(rstn),
        .REQ_VALID(valid), .REQ_ADDR(req.addr), .REQ_WDATA(req.wdata), .REQ_WRITE(req.write),
        .REQ_INTERNAL(req.internal), .REQ_READY(ready), .DONE(done), .RDATA(rdata),
        .BOOTED(booted), .START_VEC(start_vec), .ADDR_STROBE_N(as_n),
        .DATA_STROBE_N(ds_n), .RW(rw), .UPPER_ADDR_LINES(upper),
        .MUX_ADDR_DATA_LANE_OUT(lane_out), .MUX_ADDR_DATA_LANE_OE(oe),
        .MUX_ADDR_DATA_LANE_IN(lane));
    emsb_mem_model model (.clk(clk), .as_n(as_n), .ds_n(ds_n), .rw(rw), .upper(upper),
        .dut_out(lane_out), .dut_oe(oe), .lane(lane));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic w,
        input logic i);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 60)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 60)
        begin
            failures++;
            $display("BAD %0t ready never rose", $time);
        end
        req = '{a, d, w, i};
        valid = 1'b1;
        @(posedge clk);
        #1;
        valid = 1'b0;
        n = 1;
        while (done !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(16'(n), 16'h0005);
    endtask
    task automatic t_boot;
        int n;
        n = 0;
        while (booted !== 1'b1 && n < 60)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(start_vec, 16'h1234);
    endtask
    task automatic t_ext;
        cyc(16'hFFA5, 8'h5A, 1'b1, 1'b0);
        cyc(16'h0123, 8'hC3, 1'b1, 1'b0);
        chk(16'(model.mem[16'h07A5]), 16'h005A);
        cyc(16'h07A5, 8'h00, 1'b0, 1'b0);
        chk(16'(rdata), 16'h005A);
        cyc(16'h0123, 8'h00, 1'b0, 1'b0);
        chk(16'(rdata), 16'h00C3);
    endtask
    task automatic t_int;
        int w;
        w = rw_lows;
        cyc(16'h07A5, 8'hFF, 1'b1, 1'b1);
        chk(16'(model.mem[16'h07A5]), 16'h005A);
        chk(16'(rw_lows - w), 16'h0000);
        cyc(16'h07A5, 8'h00, 1'b0, 1'b1);
        chk(16'(rdata), 16'h0000);
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        #1;
        rstn = 1'b1;
        t_boot();
        t_ext();
        t_int();
        close_out();
    end
    initial
    begin
        #20000;
        failures++;
        close_out();
    end
endmodule
bind emsb_top emsb_checker #(.ADDR_W(ADDR_W)) u_chk (.REF_CLK(REF_CLK), .RSTN(RSTN),
    .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_INTERNAL(REQ_INTERNAL),
    .REQ_READY(REQ_READY), .DONE(DONE), .ADDR_STROBE_N(ADDR_STROBE_N),
    .DATA_STROBE_N(DATA_STROBE_N), .RW(RW), .UPPER_ADDR_LINES(UPPER_ADDR_LINES),
    .MUX_ADDR_DATA_LANE_OUT(MUX_ADDR_DATA_LANE_OUT),
    .MUX_ADDR_DATA_LANE_OE(MUX_ADDR_DATA_LANE_OE));
`default_nettype wire
